// ===== rtl/wake_pkg.sv
// Constants shared by the host wake-up handshake block
package wake_pkg;
    // ************************************************
    // Clock rate
    // ************************************************
    localparam int unsigned CLK_KHZ = 25000;

    // ************************************************
    // Times in their own units
    // ************************************************
    localparam int unsigned OSC_START_US = 2000;
    localparam int unsigned WAKE_LIMIT_MS = 12;
    localparam int unsigned PD_ENTRY_MS = 1;
    localparam int unsigned AWAKE_REPLY_US = 10;

    // ************************************************
    // Derived cycle counts (microsecond times round down)
    // ************************************************
    localparam int unsigned OSC_START_CYCLES = OSC_START_US * CLK_KHZ / 1000;
    localparam int unsigned WAKE_LIMIT_CYCLES = WAKE_LIMIT_MS * CLK_KHZ;
    localparam int unsigned PD_ENTRY_CYCLES = PD_ENTRY_MS * CLK_KHZ;
    localparam int unsigned AWAKE_REPLY_CYCLES = AWAKE_REPLY_US * CLK_KHZ / 1000;

    // ************************************************
    // Counter reset and step values
    // ************************************************
    localparam logic [31:0] CNT_RESET = 32'h0000_0000;
    localparam logic [31:0] CNT_STEP = 32'h0000_0001;

    typedef enum {
        ST_AWAKE,
        ST_PD_ENTRY,
        ST_POWER_DOWN,
        ST_WAKING
    } power_state_type;
endpackage : wake_pkg

// ===== rtl/pin_sync3.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module pin_sync3 #(
    parameter logic RESET_VAL = 1'b1
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic pin,
    output logic level
);
    logic s1;
    logic s2;
    logic s3;

    // First stage feeds only the second
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            s1 <= RESET_VAL;
            s2 <= RESET_VAL;
            s3 <= RESET_VAL;
        end else begin
            s1 <= pin;
            s2 <= s1;
            s3 <= s2;
        end
    end

    // A change counts once stages two and three agree
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            level <= RESET_VAL;
        end else if (s2 == s3) begin
            level <= s3;
        end
    end
endmodule : pin_sync3

// ===== rtl/host_wakeup_handshake.sv
// Device-side wake-up and attention handshake toward the host
`timescale 1ns/1ps
// Functional notes
// - After target-init acknowledge, enter power down when no RF field.
// - Power down after target-init ends on RF field or host command.
// - Activated target drives attention low when response is ready.
// - Request falling edge makes device send response and release attention.
// - Attention low at most wake limit, then response is sent anyway.
// - Emulated mode module event asserts attention; status query releases it.
// - Low battery on I2C ignores request line and hides module events.
// - Low battery on I2C stretches clock on each command until ready.
// - Normal I2C asserts attention for acknowledge and again for response.
// - I2C request while powered down wakes device and asserts attention.
// - Own address in host command write releases attention.
// - Response ready asserts attention; own address in read releases it.
// - Request fall to attention fall within 10 us awake, plus startup asleep.
// - Without request line, waking device stretches clock after own address.
module host_wakeup_handshake
    import wake_pkg::*;
#(
    parameter int unsigned OSC_CYCLES = OSC_START_CYCLES,
    parameter int unsigned LIMIT_CYCLES = WAKE_LIMIT_CYCLES,
    parameter int unsigned ENTRY_CYCLES = PD_ENTRY_CYCLES
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic link_is_i2c,
    input wire logic low_battery_mode,
    input wire logic emulated_module_mode,
    input wire logic power_down_cmd,
    input wire logic target_init_acked,
    input wire logic cmd_rx_start,
    input wire logic ack_frame_ready,
    input wire logic response_ready,
    input wire logic module_event,
    input wire logic status_query_rx,
    input wire logic addr_match_write,
    input wire logic addr_match_read,
    input wire logic rf_field_pin,
    input wire logic host_req_n_pin,
    input wire logic scl_in,
    output logic scl_out,
    output logic scl_oe,
    output logic device_attention_line_n,
    output logic send_response,
    output logic powered_down,
    output logic core_ready
);
    // ************************************************
    // Pin synchronisers
    // ************************************************
    logic req_n;
    logic rf_field;
    logic scl_level;
    logic req_n_prev;
    logic req_fall;

    pin_sync3 #(.RESET_VAL(1'b1)) req_sync (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .pin(host_req_n_pin),
        .level(req_n)
    );

    pin_sync3 #(.RESET_VAL(1'b0)) rf_sync (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .pin(rf_field_pin),
        .level(rf_field)
    );

    pin_sync3 #(.RESET_VAL(1'b1)) scl_sync (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .pin(scl_in),
        .level(scl_level)
    );

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            req_n_prev <= 1'b1;
        end else begin
            req_n_prev <= req_n;
        end
    end

    // Low battery on I2C makes the request line meaningless
    logic lowbat_i2c;
    assign lowbat_i2c = link_is_i2c && low_battery_mode;
    assign req_fall = req_n_prev && !req_n && !lowbat_i2c;

    // ************************************************
    // Power state machine
    // ************************************************
    power_state_type state;
    logic [31:0] pwr_cnt;
    logic wake_evt;
    logic wake_by_req;
    logic wake_done;

    assign wake_evt = rf_field || cmd_rx_start || addr_match_write || req_fall;
    assign wake_done = (state == ST_WAKING) && (pwr_cnt == 32'(OSC_CYCLES - 1));

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            state <= ST_AWAKE;
            pwr_cnt <= CNT_RESET;
        end else begin
            pwr_cnt <= pwr_cnt + CNT_STEP;
            case (state)
                ST_AWAKE: begin
                    pwr_cnt <= CNT_RESET;
                    if (power_down_cmd || (target_init_acked && !rf_field)) begin
                        state <= ST_PD_ENTRY;
                    end
                end
                ST_PD_ENTRY: begin
                    if (wake_evt) begin
                        state <= ST_AWAKE;
                        pwr_cnt <= CNT_RESET;
                    end else if (pwr_cnt == 32'(ENTRY_CYCLES - 1)) begin
                        state <= ST_POWER_DOWN;
                        pwr_cnt <= CNT_RESET;
                    end
                end
                ST_POWER_DOWN: begin
                    pwr_cnt <= CNT_RESET;
                    if (wake_evt) begin
                        state <= ST_WAKING;
                    end
                end
                ST_WAKING: begin
                    if (wake_done) begin
                        state <= ST_AWAKE;
                        pwr_cnt <= CNT_RESET;
                    end
                end
                default: begin
                    state <= ST_AWAKE;
                    pwr_cnt <= CNT_RESET;
                end
            endcase
        end
    end

    // Remember what woke the core; decides attention or clock stretch
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            wake_by_req <= 1'b0;
        end else if (state == ST_POWER_DOWN && wake_evt) begin
            wake_by_req <= req_fall;
        end else if (state == ST_AWAKE) begin
            wake_by_req <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            powered_down <= 1'b0;
            core_ready <= 1'b1;
        end else begin
            powered_down <= (state == ST_POWER_DOWN);
            core_ready <= (state == ST_AWAKE) || (state == ST_PD_ENTRY);
        end
    end

    // ************************************************
    // Serial target response timing
    // ************************************************
    logic target_active;
    logic resp_wait;
    logic [31:0] resp_cnt;
    logic resp_go;
    logic resp_timeout;

    assign resp_timeout = resp_wait && (resp_cnt == 32'(LIMIT_CYCLES - 1));
    assign resp_go = resp_wait && (req_fall || resp_timeout);

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            target_active <= 1'b0;
        end else if (target_init_acked) begin
            target_active <= 1'b1;
        end else if (resp_go) begin
            target_active <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            resp_wait <= 1'b0;
            resp_cnt <= CNT_RESET;
        end else if (resp_go) begin
            resp_wait <= 1'b0;
            resp_cnt <= CNT_RESET;
        end else if (!link_is_i2c && target_active && response_ready) begin
            resp_wait <= 1'b1;
            resp_cnt <= CNT_RESET;
        end else if (resp_wait) begin
            resp_cnt <= resp_cnt + CNT_STEP;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            send_response <= 1'b0;
        end else begin
            send_response <= resp_go;
        end
    end

    // ************************************************
    // Attention line
    // ************************************************
    logic attn_set;
    logic attn_clr;
    logic i2c_req_ack;

    // Awake I2C device answers a request at once; asleep one after startup
    assign i2c_req_ack = link_is_i2c && ((req_fall && state == ST_AWAKE) ||
                                         (wake_done && wake_by_req));

    always_comb begin
        attn_set = 1'b0;
        attn_clr = 1'b0;
        if (link_is_i2c && (ack_frame_ready || response_ready)) begin
            attn_set = 1'b1;
        end
        if (!link_is_i2c && target_active && response_ready) begin
            attn_set = 1'b1;
        end
        if (emulated_module_mode && !lowbat_i2c && module_event) begin
            attn_set = 1'b1;
        end
        if (i2c_req_ack) begin
            attn_set = 1'b1;
        end
        if (resp_go || status_query_rx) begin
            attn_clr = 1'b1;
        end
        if (link_is_i2c && (addr_match_write || addr_match_read)) begin
            attn_clr = 1'b1;
        end
    end

    // A new event beats a release landing in the same cycle
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            device_attention_line_n <= 1'b1;
        end else if (attn_set) begin
            device_attention_line_n <= 1'b0;
        end else if (attn_clr) begin
            device_attention_line_n <= 1'b1;
        end
    end

    // ************************************************
    // I2C clock stretching
    // ************************************************
    logic stretch_req;
    logic not_ready;

    assign not_ready = (state == ST_POWER_DOWN) || (state == ST_WAKING);

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            stretch_req <= 1'b0;
        end else if (link_is_i2c && addr_match_write && !wake_by_req &&
                     (not_ready || wake_evt && state == ST_POWER_DOWN)) begin
            stretch_req <= 1'b1;
        end else if (state == ST_AWAKE) begin
            stretch_req <= 1'b0;
        end
    end

    // Grab the line only while it is already low, so no high phase is cut
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            scl_oe <= 1'b0;
            scl_out <= 1'b0;
        end else begin
            scl_oe <= stretch_req && (scl_oe || !scl_level);
            scl_out <= 1'b0;
        end
    end

    // ************************************************
    // Assertions
    // ************************************************
    localparam int REPLY_MAX = AWAKE_REPLY_CYCLES;

    AST_PD_ENTRY: assert property (@(posedge ref_clk) disable iff (!rst_n)
        state == ST_AWAKE && target_init_acked && !rf_field && !power_down_cmd
        |=> state == ST_PD_ENTRY)
        else $error("No power down entry after target init");

    AST_PD_WAKE: assert property (@(posedge ref_clk) disable iff (!rst_n)
        state == ST_POWER_DOWN && rf_field |=> state == ST_WAKING ##1 pwr_cnt == 32'h0000_0001)
        else $error("RF field did not wake the core");

    AST_RESP_ATTN: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !link_is_i2c && target_active && response_ready && !resp_wait
        |=> !device_attention_line_n && resp_wait)
        else $error("Target response did not assert attention");

    AST_REQ_SEND: assert property (@(posedge ref_clk) disable iff (!rst_n)
        resp_wait && req_fall |=> send_response ##1 !send_response)
        else $error("Request fall did not send response");

    AST_LIMIT: assert property (@(posedge ref_clk) disable iff (!rst_n)
        resp_wait |-> resp_cnt < 32'(LIMIT_CYCLES))
        else $error("Attention pulse exceeded wake limit");

    AST_STATUS_REL: assert property (@(posedge ref_clk) disable iff (!rst_n)
        status_query_rx && !attn_set |=> device_attention_line_n)
        else $error("Status query did not release attention");

    AST_LOWBAT_EVT: assert property (@(posedge ref_clk) disable iff (!rst_n)
        lowbat_i2c && module_event && !ack_frame_ready && !response_ready
        && device_attention_line_n && !i2c_req_ack |=> device_attention_line_n)
        else $error("Module event reported in low battery");

    AST_ADDR_REL: assert property (@(posedge ref_clk) disable iff (!rst_n)
        link_is_i2c && addr_match_write && !attn_set |=> $rose(device_attention_line_n)
        or device_attention_line_n)
        else $error("Own address did not release attention");

    AST_AWAKE_REPLY: assert property (@(posedge ref_clk) disable iff (!rst_n)
        link_is_i2c && state == ST_AWAKE && req_fall && !attn_clr
        |-> ##[1:REPLY_MAX] !device_attention_line_n)
        else $error("Awake request not answered in time");

    AST_STRETCH: assert property (@(posedge ref_clk) disable iff (!rst_n)
        scl_oe |-> stretch_req && state != ST_AWAKE || $past(stretch_req))
        else $error("Clock held low while core is ready");

    COV_TIMEOUT: cover property (@(posedge ref_clk) disable iff (!rst_n) resp_timeout);
    COV_REQ_WAKE: cover property (@(posedge ref_clk) disable iff (!rst_n)
        wake_done && wake_by_req && link_is_i2c);
    COV_STRETCH: cover property (@(posedge ref_clk) disable iff (!rst_n) $rose(scl_oe));
    COV_EVENT: cover property (@(posedge ref_clk) disable iff (!rst_n)
        module_event && emulated_module_mode ##[1:8] status_query_rx);
endmodule : host_wakeup_handshake

// ===== bench/host_model.sv
// Host controller model: request line and the shared I2C clock wire
`timescale 1ns/1ps
module host_model (
    input wire logic ref_clk,
    input wire logic scl_oe,
    input wire logic scl_out,
    output logic host_req_n_pin,
    output logic scl_in
);
    logic host_scl_low;
    int unsigned waited;

    initial begin
        host_req_n_pin = 1'b1;
        host_scl_low = 1'b0;
    end

    // Open drain with pull-up: the wire is low while either party pulls it
    assign scl_in = ((scl_oe && !scl_out) || host_scl_low) ? 1'b0 : 1'b1;

    // ************************************************
    // Request line
    // ************************************************
    // Caller picks the length: 1 us when awake, startup time when asleep
    task automatic req_pulse(input int cycles);
        host_req_n_pin = 1'b0;
        repeat (cycles) @(negedge ref_clk);
        host_req_n_pin = 1'b1;
    endtask : req_pulse

    // ************************************************
    // I2C clock, 320 ns period, still outside frames
    // ************************************************
    task automatic clock_bits(input int bits);
        repeat (bits) begin
            #160 host_scl_low = 1'b1;
            #160 host_scl_low = 1'b0;
        end
    endtask : clock_bits

    task automatic hold_low(input logic low);
        host_scl_low = low;
    endtask : hold_low

    // Master honours stretching, but only for a bounded time
    task automatic wait_released(input int limit);
        waited = 0;
        while (scl_in !== 1'b1 && waited < limit) begin
            @(negedge ref_clk);
            waited++;
        end
    endtask : wait_released
endmodule : host_model

// ===== bench/host_wakeup_handshake_tb.sv
// Self-checking bench for the host wake-up handshake block
`timescale 1ns/1ps
module host_wakeup_handshake_tb;
    import wake_pkg::*;
    localparam int OSC = 20;
    localparam int LIM = 40;
    localparam int ENT = 10;

    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic link_is_i2c = 1'b0;
    logic low_battery_mode = 1'b0;
    logic emulated_module_mode = 1'b0;
    logic power_down_cmd = 1'b0;
    logic target_init_acked = 1'b0;
    logic cmd_rx_start = 1'b0;
    logic ack_frame_ready = 1'b0;
    logic response_ready = 1'b0;
    logic module_event = 1'b0;
    logic status_query_rx = 1'b0;
    logic addr_match_write = 1'b0;
    logic addr_match_read = 1'b0;
    logic rf_field_pin = 1'b0;
    logic host_req_n_pin;
    logic scl_in;
    logic scl_out;
    logic scl_oe;
    logic device_attention_line_n;
    logic send_response;
    logic powered_down;
    logic core_ready;
    int errors = 0;
    int n_tests = 0;
    int n_send = 0;
    int n;

    always #20 ref_clk = ~ref_clk;

    host_wakeup_handshake #(.OSC_CYCLES(OSC), .LIMIT_CYCLES(LIM), .ENTRY_CYCLES(ENT)) u_dut (
        .ref_clk(ref_clk), .rst_n(rst_n), .link_is_i2c(link_is_i2c),
        .low_battery_mode(low_battery_mode), .emulated_module_mode(emulated_module_mode),
        .power_down_cmd(power_down_cmd), .target_init_acked(target_init_acked),
        .cmd_rx_start(cmd_rx_start), .ack_frame_ready(ack_frame_ready),
        .response_ready(response_ready), .module_event(module_event),
        .status_query_rx(status_query_rx), .addr_match_write(addr_match_write),
        .addr_match_read(addr_match_read), .rf_field_pin(rf_field_pin),
        .host_req_n_pin(host_req_n_pin), .scl_in(scl_in), .scl_out(scl_out),
        .scl_oe(scl_oe), .device_attention_line_n(device_attention_line_n),
        .send_response(send_response), .powered_down(powered_down), .core_ready(core_ready)
    );

    host_model u_host (
        .ref_clk(ref_clk), .scl_oe(scl_oe), .scl_out(scl_out),
        .host_req_n_pin(host_req_n_pin), .scl_in(scl_in)
    );

    always @(posedge ref_clk) begin
        if (send_response === 1'b1) n_send <= n_send + 1;
    end

    // ************************************************
    // Shared helpers
    // ************************************************
    task automatic tick(input int cycles);
        repeat (cycles) @(negedge ref_clk);
    endtask : tick

    task automatic pulse(ref logic s);
        s = 1'b1;
        @(negedge ref_clk);
        s = 1'b0;
    endtask : pulse

    task automatic check(input logic seen, input logic exp, input string what);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: %s", $time, what);
        end
    endtask : check

    task automatic attn_step(ref logic s, input logic exp);
        pulse(s);
        tick(1);
        check(device_attention_line_n, exp, "attention level");
    endtask : attn_step

    task automatic give_verdict;
        $display("comparisons %0d, mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : give_verdict

    task automatic sleep_i2c;
        pulse(power_down_cmd);
        tick(ENT + 4);
        check(powered_down, 1'b1, "power down entered");
    endtask : sleep_i2c

    // Address byte, host parks SCL low, device must keep it low until awake
    task automatic do_stretch;
        u_host.clock_bits(9);
        // Re-align to the bench clock so the wire is not set twice in one step
        @(posedge ref_clk);
        tick(1);
        u_host.hold_low(1'b1);
        tick(8);
        pulse(addr_match_write);
        tick(4);
        u_host.hold_low(1'b0);
        tick(2);
        check(scl_oe, 1'b1, "stretch held");
        check(scl_in, 1'b0, "clock wire low");
        check(scl_out, 1'b0, "stretch drives low");
        u_host.wait_released(OSC + 10);
        tick(3);
        check(scl_oe, 1'b0, "stretch released");
        check(core_ready, 1'b1, "awake after stretch");
    endtask : do_stretch

    // ************************************************
    // Scenarios
    // ************************************************
    task automatic t_serial_target;
        pulse(target_init_acked);
        tick(ENT + 4);
        check(powered_down, 1'b1, "sleep after target ack");
        check(core_ready, 1'b0, "core stopped");
        rf_field_pin = 1'b1;
        tick(3);
        check(powered_down, 1'b1, "field not yet seen");
        tick(5);
        check(powered_down, 1'b0, "field wakes core");
        tick(OSC + 2);
        check(core_ready, 1'b1, "core ready after startup");
        n = n_send;
        attn_step(response_ready, 1'b0);
        u_host.req_pulse(30);
        tick(8);
        check(n_send == n + 1, 1'b1, "response sent on request");
        check(device_attention_line_n, 1'b1, "attention released");
    endtask : t_serial_target

    task automatic t_serial_timeout;
        pulse(target_init_acked);
        n = n_send;
        attn_step(response_ready, 1'b0);
        tick(LIM - 4);
        check(device_attention_line_n, 1'b0, "still waiting for host");
        check(n_send == n, 1'b1, "no early response");
        tick(8);
        check(device_attention_line_n, 1'b1, "pulse limited");
        check(n_send == n + 1, 1'b1, "response sent anyway");
    endtask : t_serial_timeout

    // Serial wake by command start, then by request pulse; no wake sign checked after the request wake
    task automatic t_serial_wake;
        sleep_i2c();
        pulse(cmd_rx_start);
        tick(2);
        check(powered_down, 1'b0, "command wakes core");
        tick(OSC + 2);
        check(core_ready, 1'b1, "ready after command wake");
        sleep_i2c();
        u_host.req_pulse(OSC + 2);
        tick(OSC);
        check(powered_down, 1'b0, "request wakes core");
        check(core_ready, 1'b1, "ready after request wake");
        check(device_attention_line_n, 1'b1, "no wake sign on serial");
    endtask : t_serial_wake

    // Emulated mode is never combined with the power-down command
    task automatic t_emulated;
        emulated_module_mode = 1'b1;
        attn_step(module_event, 1'b0);
        attn_step(status_query_rx, 1'b1);
        emulated_module_mode = 1'b0;
    endtask : t_emulated

    task automatic t_i2c_frames;
        link_is_i2c = 1'b1;
        attn_step(ack_frame_ready, 1'b0);
        attn_step(addr_match_read, 1'b1);
        attn_step(response_ready, 1'b0);
        attn_step(addr_match_read, 1'b1);
        attn_step(ack_frame_ready, 1'b0);
        attn_step(addr_match_write, 1'b1);
    endtask : t_i2c_frames

    // Host watches attention with the guard delay as its timeout
    task automatic t_i2c_req_wake(input logic asleep);
        if (asleep) sleep_i2c();
        fork
            u_host.req_pulse(asleep ? OSC + 2 : 26);
        join_none
        for (n = 0; n < OSC + 260 && device_attention_line_n !== 1'b0; n++) tick(1);
        check(device_attention_line_n, 1'b0, "request answered");
        check(n <= (asleep ? OSC + 250 : 250), 1'b1, "answer in time");
        check(n >= (asleep ? OSC : 0), 1'b1, "not before startup");
        tick(30);
        attn_step(addr_match_write, 1'b1);
    endtask : t_i2c_req_wake

    task automatic t_lowbat;
        low_battery_mode = 1'b1;
        emulated_module_mode = 1'b1;
        // Power-down command is barred with emulated mode; sleep via target init
        pulse(target_init_acked);
        tick(ENT + 4);
        u_host.req_pulse(OSC + 2);
        tick(OSC + 10);
        check(powered_down, 1'b1, "request ignored");
        check(device_attention_line_n, 1'b1, "no attention on request");
        attn_step(module_event, 1'b1);
        do_stretch();
        low_battery_mode = 1'b0;
        emulated_module_mode = 1'b0;
    endtask : t_lowbat

    initial begin
        tick(4);
        check(device_attention_line_n, 1'b1, "reset attention");
        check(send_response, 1'b0, "reset send");
        check(scl_oe, 1'b0, "reset stretch");
        check(powered_down, 1'b0, "reset power");
        check(core_ready, 1'b1, "reset ready");
        rst_n = 1'b1;
        tick(6);
        t_serial_target();
        t_serial_timeout();
        rf_field_pin = 1'b0;
        tick(6);
        t_serial_wake();
        t_emulated();
        t_i2c_frames();
        t_i2c_req_wake(1'b0);
        // Wait out the power-down entry window before the next command
        tick(ENT + 2);
        t_i2c_req_wake(1'b1);
        // Startup time passes before commands that must be understood
        tick(OSC);
        sleep_i2c();
        do_stretch();
        t_lowbat();
        give_verdict();
    end

    initial begin
        repeat (5000) @(posedge ref_clk);
        errors++;
        give_verdict();
    end
endmodule : host_wakeup_handshake_tb
